// file: common/sock_state_pkg.sv
// Package for the socket present-state and force-event register block.
// Assumes a plain one-cycle register port; offsets are byte addresses.
package sock_state_pkg;
   localparam logic [7:0] PRESENT_STATE_OFFSET = 8'h08;
   localparam logic [7:0] FORCE_EVENT_OFFSET = 8'h0c;
   localparam logic [7:0] CONTROL_STATUS_OFFSET = 8'h14;
   localparam logic [7:0] EVENT_FLAGS_OFFSET = 8'h18;
   localparam int VIDEO_CAP_BIT = 27;
   localparam int REINTERROGATE_BIT = 14;
   localparam int VOLT_HI_BIT = 13;
   localparam int VOLT_LO_BIT = 10;
   localparam int INVALID_SUPPLY_BIT = 9;
   localparam int POTENTIAL_LOSS_BIT = 8;
   localparam int UNRECOGNIZED_BIT = 7;
   localparam int IRQ_LEVEL_BIT = 6;
   localparam int CARDBUS_BIT = 5;
   localparam int LEGACY_BIT = 4;
   localparam int POWERED_BIT = 3;
   localparam int DETECT_B_BIT = 2;
   localparam int DETECT_A_BIT = 1;
   localparam int STATUS_BIT = 0;
   localparam int CTRL_INTERROG_BIT = 0;
   localparam int CTRL_AUTO_POWER_BIT = 1;
   localparam logic [31:0] PRESENT_RESET = 32'h0000_0000;
   localparam logic [3:0] EVENT_RESET = 4'h0;
   localparam logic [1:0] DETECT_RESET = 2'h3;
   localparam logic AUTO_POWER_RESET = 1'h1;
   localparam logic [3:0] INTERROG_CYCLES = 4'h8;
   typedef struct packed {
      logic detect_b;
      logic detect_a;
      logic status_change;
      logic irq_level;
   } card_pins_t;
   typedef struct packed {
      logic valid;
      logic cardbus;
      logic legacy;
      logic [3:0] volts;
   } interrog_result_t;
   typedef enum logic [1:0] {
      IDLE,
      INTERROGATE,
      UPDATE
   } interrog_state_t;
endpackage

// file: hdl/sock_state_regs.sv
// Socket present-state and force-event registers with card interrogation hold-off.
// Assumes card pins synchronous to core_clk_in; interrogation result from a card identifier.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
// Functional notes
// - Potential-loss flag at bit 8 on lossy removal
// - Unrecognized flag bit 7, held until valid card
// - Bit 6 follows live interrupt pin
// - Bit 5 CardBus flag changes only on interrogation or force write
// - Bit 4 legacy flag changes only on interrogation or force write
// - Bit 3 shows last power request result
// - Bits 2,1 mirror detect pins
// - Detect bits frozen during interrogation
// - Bit 0 follows live status-change pin
// - Bit 14 reinterrogates, refreshes, re-enables power
// - Force bit 27 writes video capability
// - Force bits 13-10 write voltage flags
// - Forced voltage bits disable auto power
// - Force bit 9 writes invalid-supply flag
// - Force bits 8,7,5,4 write state flags
// - Force bit 3 writes power event only
// - Force bits 2,1 write detect events only
// - Force bit 0 writes status event only
// - Reserved force bits ignored, read zero
// - Supply and type refreshed only at interrogation (insertion or bit 14)
module sock_state_regs (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire sock_state_pkg::card_pins_t pins_in,
   input wire logic card_inserted_in,
   input wire logic card_removed_lossy_in,
   input wire sock_state_pkg::interrog_result_t interrog_in,
   input wire logic power_good_in,
   output logic auto_power_en_out,
   output logic interrogating_out,
   output logic [3:0] event_force_out
);
   import sock_state_pkg::*;

   logic [31:0] present_reg, present_next;
   logic [1:0] detect_reg, detect_next;
   logic [3:0] event_reg, event_next;
   logic auto_power_reg, auto_power_next;
   logic [31:0] rdata_reg, rdata_next;
   interrog_state_t state_reg, state_next;
   logic [3:0] count_reg, count_next;
   logic wr_present, wr_force, wr_event, start_interrog;

   assign wr_force = wr_in && (addr_in == FORCE_EVENT_OFFSET);
   assign wr_event = wr_in && (addr_in == EVENT_FLAGS_OFFSET);
   assign wr_present = wr_force;
   assign start_interrog = card_inserted_in || (wr_force && wdata_in[REINTERROGATE_BIT]);

   // Interrogation sequencer
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      unique case (state_reg)
         IDLE: begin
            if (start_interrog) begin
               state_next = INTERROGATE;
               count_next = INTERROG_CYCLES;
            end
         end
         INTERROGATE: begin
            count_next = count_reg - 4'h1;
            if (count_reg == 4'h1) begin
               state_next = UPDATE;
            end
         end
         UPDATE: begin
            state_next = IDLE;
         end
         default: begin
            state_next = IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_reg <= IDLE;
         count_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // Present state, detect hold, events and auto power
   always_comb begin
      present_next = present_reg;
      auto_power_next = auto_power_reg;
      event_next = event_reg;
      detect_next = detect_reg;
      if (state_reg == IDLE) begin
         detect_next = {pins_in.detect_b, pins_in.detect_a};
      end
      present_next[POWERED_BIT] = power_good_in;
      if (state_reg == UPDATE) begin
         // Refresh only here, so a noisy card cannot churn type bits
         present_next[UNRECOGNIZED_BIT] = ~interrog_in.valid;
         if (interrog_in.valid) begin
            present_next[CARDBUS_BIT] = interrog_in.cardbus;
            present_next[LEGACY_BIT] = interrog_in.legacy;
            present_next[VOLT_HI_BIT:VOLT_LO_BIT] = interrog_in.volts;
         end
         auto_power_next = 1'b1;
      end
      if (wr_present) begin
         present_next[VIDEO_CAP_BIT] = wdata_in[VIDEO_CAP_BIT];
         present_next[VOLT_HI_BIT:VOLT_LO_BIT] = wdata_in[VOLT_HI_BIT:VOLT_LO_BIT];
         if (|wdata_in[VOLT_HI_BIT:VOLT_LO_BIT]) begin
            auto_power_next = 1'b0;
         end
         present_next[INVALID_SUPPLY_BIT] = wdata_in[INVALID_SUPPLY_BIT];
         present_next[POTENTIAL_LOSS_BIT] = wdata_in[POTENTIAL_LOSS_BIT];
         present_next[UNRECOGNIZED_BIT] = wdata_in[UNRECOGNIZED_BIT];
         present_next[CARDBUS_BIT] = wdata_in[CARDBUS_BIT];
         present_next[LEGACY_BIT] = wdata_in[LEGACY_BIT];
      end
      if (card_removed_lossy_in) begin
         // Loss event wins over a forced clear in the same cycle
         present_next[POTENTIAL_LOSS_BIT] = 1'b1;
      end
      if (wr_event) begin
         // Write one to clear
         event_next = event_reg & ~wdata_in[3:0];
      end
      if (wr_force) begin
         // Set wins over a simultaneous clear
         event_next = event_next | wdata_in[3:0];
      end
      present_next[IRQ_LEVEL_BIT] = 1'b0;
      present_next[DETECT_B_BIT] = 1'b0;
      present_next[DETECT_A_BIT] = 1'b0;
      present_next[STATUS_BIT] = 1'b0;
      present_next[31:28] = 4'h0;
      present_next[26:14] = 13'h0000;
      present_next[2:0] = 3'h0;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         present_reg <= PRESENT_RESET;
         detect_reg <= DETECT_RESET;
         event_reg <= EVENT_RESET;
         auto_power_reg <= AUTO_POWER_RESET;
      end else begin
         present_reg <= present_next;
         detect_reg <= detect_next;
         event_reg <= event_next;
         auto_power_reg <= auto_power_next;
      end
   end

   // Read port; live pins merged at read time
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (rd_in) begin
         unique case (addr_in)
            PRESENT_STATE_OFFSET: begin
               rdata_next = present_reg;
               rdata_next[IRQ_LEVEL_BIT] = pins_in.irq_level;
               rdata_next[DETECT_B_BIT] = detect_reg[1];
               rdata_next[DETECT_A_BIT] = detect_reg[0];
               rdata_next[STATUS_BIT] = pins_in.status_change;
            end
            FORCE_EVENT_OFFSET: begin
               rdata_next = 32'h0000_0000;
            end
            CONTROL_STATUS_OFFSET: begin
               rdata_next[CTRL_INTERROG_BIT] = (state_reg != IDLE);
               rdata_next[CTRL_AUTO_POWER_BIT] = auto_power_reg;
            end
            EVENT_FLAGS_OFFSET: begin
               rdata_next[3:0] = event_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign auto_power_en_out = auto_power_reg;
   assign interrogating_out = (state_reg != IDLE);
   assign event_force_out = event_reg;

   // Assertions
   forced_volts_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> present_reg[VOLT_HI_BIT:VOLT_LO_BIT] == $past(wdata_in[VOLT_HI_BIT:VOLT_LO_BIT]))
      else $error("forced voltage bits not copied");
   auto_power_off_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_force && |wdata_in[VOLT_HI_BIT:VOLT_LO_BIT] && !(state_reg == UPDATE)) |=> !auto_power_reg)
      else $error("auto power not disabled");
   reinterrog_run_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == IDLE && wr_force && wdata_in[REINTERROGATE_BIT]) |=> (state_reg == INTERROGATE) [*8] ##1
      (state_reg == UPDATE) ##1 auto_power_reg)
      else $error("reinterrogation sequence wrong");
   detect_hold_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == INTERROGATE) |=> $stable(detect_reg))
      else $error("detect bits moved during interrogation");
   type_stable_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg != UPDATE && !wr_force) |=> $stable(present_reg[CARDBUS_BIT]))
      else $error("cardbus flag changed outside interrogation");
   legacy_stable_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg != UPDATE && !wr_force) |=> $stable(present_reg[LEGACY_BIT]))
      else $error("legacy flag changed outside interrogation");
   loss_set_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      card_removed_lossy_in |=> present_reg[POTENTIAL_LOSS_BIT])
      else $error("potential loss not flagged");
   event_force_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> ((event_reg & $past(wdata_in[3:0])) == $past(wdata_in[3:0])))
      else $error("forced event not set");
   force_read_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == FORCE_EVENT_OFFSET) |=> rdata_out == 32'h0000_0000)
      else $error("force register read not zero");
   status_live_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == PRESENT_STATE_OFFSET) |=> rdata_out[STATUS_BIT] == $past(pins_in.status_change))
      else $error("status bit not live");
   irq_live_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == PRESENT_STATE_OFFSET) |=> rdata_out[IRQ_LEVEL_BIT] == $past(pins_in.irq_level))
      else $error("irq bit not live");
   reserved_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      present_reg[26:14] == 13'h0000)
      else $error("reserved bits set");
   power_track_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      1'b1 |=> present_reg[POWERED_BIT] == $past(power_good_in))
      else $error("powered flag wrong");

   read_idle_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !rd_in |=> rdata_out == 32'h0000_0000)
      else $error("read data not zero when idle");

   unmapped_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in != PRESENT_STATE_OFFSET && addr_in != FORCE_EVENT_OFFSET
      && addr_in != CONTROL_STATUS_OFFSET && addr_in != EVENT_FLAGS_OFFSET) |=> rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");

   reserved_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == PRESENT_STATE_OFFSET) |=> (rdata_out[31:28] == 4'h0 && rdata_out[26:14] == 13'h0000))
      else $error("reserved read bits set");

   top_reserved_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      present_reg[31:28] == 4'h0)
      else $error("top reserved bits set");

   stored_live_zero_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (present_reg[IRQ_LEVEL_BIT] == 1'b0 && present_reg[2:0] == 3'h0))
      else $error("live bit positions stored");

   detect_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == PRESENT_STATE_OFFSET) |=> rdata_out[DETECT_B_BIT:DETECT_A_BIT] == $past(detect_reg))
      else $error("detect bits not read");

   detect_track_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == IDLE) |=> detect_reg == $past({pins_in.detect_b, pins_in.detect_a}))
      else $error("detect bits not tracking");

   present_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == PRESENT_STATE_OFFSET) |=>
      (rdata_out[VIDEO_CAP_BIT:UNRECOGNIZED_BIT] == $past(present_reg[VIDEO_CAP_BIT:UNRECOGNIZED_BIT])
      && rdata_out[CARDBUS_BIT:POWERED_BIT] == $past(present_reg[CARDBUS_BIT:POWERED_BIT])))
      else $error("present state read wrong");

   video_cap_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> present_reg[VIDEO_CAP_BIT] == $past(wdata_in[VIDEO_CAP_BIT]))
      else $error("video capability not forced");

   video_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !wr_force |=> $stable(present_reg[VIDEO_CAP_BIT]))
      else $error("video capability moved");

   invalid_supply_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> present_reg[INVALID_SUPPLY_BIT] == $past(wdata_in[INVALID_SUPPLY_BIT]))
      else $error("invalid supply not forced");

   supply_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !wr_force |=> $stable(present_reg[INVALID_SUPPLY_BIT]))
      else $error("invalid supply flag moved");

   forced_unrec_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> present_reg[UNRECOGNIZED_BIT] == $past(wdata_in[UNRECOGNIZED_BIT]))
      else $error("unrecognized flag not forced");

   forced_type_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force |=> present_reg[CARDBUS_BIT:LEGACY_BIT] == $past(wdata_in[CARDBUS_BIT:LEGACY_BIT]))
      else $error("card type not forced");

   forced_loss_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_force && !card_removed_lossy_in) |=> present_reg[POTENTIAL_LOSS_BIT] == $past(wdata_in[POTENTIAL_LOSS_BIT]))
      else $error("potential loss not forced");

   loss_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (!card_removed_lossy_in && !wr_force) |=> $stable(present_reg[POTENTIAL_LOSS_BIT]))
      else $error("potential loss moved");

   unrec_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg != UPDATE && !wr_force) |=> $stable(present_reg[UNRECOGNIZED_BIT]))
      else $error("unrecognized flag moved");

   unrec_update_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE && !wr_force) |=> present_reg[UNRECOGNIZED_BIT] == !$past(interrog_in.valid))
      else $error("unrecognized flag not refreshed");

   type_update_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE && interrog_in.valid && !wr_force) |=> present_reg[CARDBUS_BIT] == $past(interrog_in.cardbus))
      else $error("cardbus flag not refreshed");

   legacy_update_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE && interrog_in.valid && !wr_force) |=> present_reg[LEGACY_BIT] == $past(interrog_in.legacy))
      else $error("legacy flag not refreshed");

   volts_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg != UPDATE && !wr_force) |=> $stable(present_reg[VOLT_HI_BIT:VOLT_LO_BIT]))
      else $error("voltage flags moved");

   volts_update_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE && interrog_in.valid && !wr_force) |=>
      present_reg[VOLT_HI_BIT:VOLT_LO_BIT] == $past(interrog_in.volts))
      else $error("voltage flags not refreshed");

   auto_power_on_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE && !wr_force) |=> auto_power_reg)
      else $error("auto power not re-enabled");

   auto_power_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg != UPDATE && !(wr_force && |wdata_in[VOLT_HI_BIT:VOLT_LO_BIT])) |=> $stable(auto_power_reg))
      else $error("auto power moved");

   insert_run_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == IDLE && card_inserted_in) |=> (state_reg == INTERROGATE) [*8] ##1 (state_reg == UPDATE))
      else $error("insertion interrogation wrong");

   update_end_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_reg == UPDATE) |=> (state_reg == IDLE))
      else $error("update not single cycle");

   events_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (!wr_force && !wr_event) |=> $stable(event_reg))
      else $error("event bits moved");

   event_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_event && !wr_force) |=> (event_reg & $past(wdata_in[3:0])) == 4'h0)
      else $error("event bits not cleared");

   event_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == EVENT_FLAGS_OFFSET) |=> rdata_out[3:0] == $past(event_reg))
      else $error("event read wrong");

   ctrl_read_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == CONTROL_STATUS_OFFSET) |=> rdata_out[CTRL_AUTO_POWER_BIT] == $past(auto_power_reg))
      else $error("auto power read wrong");

   ctrl_busy_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (rd_in && addr_in == CONTROL_STATUS_OFFSET) |=> rdata_out[CTRL_INTERROG_BIT] == $past(state_reg != IDLE))
      else $error("interrogation flag read wrong");

   insert_cov: cover property (@(posedge core_clk_in) disable iff (reset_in)
      card_inserted_in ##1 (state_reg == INTERROGATE) [*8] ##1 (state_reg == UPDATE));
   force_cov: cover property (@(posedge core_clk_in) disable iff (reset_in)
      wr_force && |wdata_in[VOLT_HI_BIT:VOLT_LO_BIT]);
   event_cov: cover property (@(posedge core_clk_in) disable iff (reset_in)
      wr_event && |(event_reg & wdata_in[3:0]));
   loss_cov: cover property (@(posedge core_clk_in) disable iff (reset_in)
      card_removed_lossy_in ##1 present_reg[POTENTIAL_LOSS_BIT]);
endmodule

// file: verification/card_model.sv
// Card in the socket: detect, interrupt and status pins plus the identifier result.
// Assumes the bench moves its controls by non-blocking assignment just after a rising edge.
`timescale 1ns/100ps
module card_model (
   input wire logic core_clk_in,
   input wire logic plug_in,
   input wire logic cardbus_in,
   input wire logic valid_in,
   input wire logic irq_in,
   input wire logic sts_in,
   output sock_state_pkg::card_pins_t pins_out,
   output sock_state_pkg::interrog_result_t interrog_out,
   output logic inserted_out
);
   import sock_state_pkg::*;
   logic [2:0] plug_reg;
   logic seated;
   always_ff @(posedge core_clk_in) begin
      plug_reg <= {plug_reg[1:0], plug_in};
   end
   // Detect contacts close late, so a change lands inside interrogation
   assign seated = plug_in & plug_reg[2];
   assign pins_out = '{detect_b: ~seated, detect_a: ~seated, status_change: sts_in, irq_level: irq_in};
   assign inserted_out = plug_reg[0] & ~plug_reg[1];
   assign interrog_out = '{valid: valid_in, cardbus: cardbus_in, legacy: ~cardbus_in,
      volts: cardbus_in ? 4'h2 : 4'h1};
endmodule

// file: verification/sock_state_regs_bench.sv
// Self-checking bench for the socket present-state and force-event registers.
// Assumes card_model on the pin side and the one-cycle register port.
`timescale 1ns/100ps
module sock_state_regs_bench;
   import sock_state_pkg::*;
   logic clk, rst, wr, rd, lossy, pgood, plug, cb, valid, irq, sts, ins, apwr, busy;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] evt;
   card_pins_t pins;
   interrog_result_t idr;
   int err_total, num_checks, n;
   sock_state_regs u_dut (.core_clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdata), .pins_in(pins), .card_inserted_in(ins), .card_removed_lossy_in(lossy),
      .interrog_in(idr), .power_good_in(pgood), .auto_power_en_out(apwr), .interrogating_out(busy),
      .event_force_out(evt));
   card_model u_card (.core_clk_in(clk), .plug_in(plug), .cardbus_in(cb), .valid_in(valid), .irq_in(irq),
      .sts_in(sts), .pins_out(pins), .interrog_out(idr), .inserted_out(ins));
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] m = 32'hFFFF_FFFF);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, rdata & m, exp);
      @(posedge clk);
   endtask
   task automatic wait_for(input logic lvl);
      n = 0;
      do begin
         @(posedge clk);
         n++;
         #1;
      end while (busy !== lvl && n < 100);
      @(posedge clk);
   endtask
   task automatic t_reset();
      rd_chk("present", 8'h08, 32'h0000_0006);
      rd_chk("force", 8'h0c, 32'h0000_0000);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      chk("auto power", 32'(apwr), 32'h0000_0001);
      chk("events", 32'(evt), 32'h0000_0000);
   endtask
   task automatic t_live();
      irq <= 1'b1;
      sts <= 1'b1;
      pgood <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk("live pins", 8'h08, 32'h0000_004F);
   endtask
   task automatic t_insert();
      cb <= 1'b1;
      valid <= 1'b1;
      plug <= 1'b1;
      wait_for(1'b1);
      repeat (3) @(posedge clk);
      rd_chk("held detect", 8'h08, 32'h0000_004F);
      rd_chk("busy flag", 8'h14, 32'h0000_0003);
      wait_for(1'b0);
      rd_chk("cardbus id", 8'h08, 32'h0000_0869);
      cb <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk("no refresh", 8'h08, 32'h0000_0869);
   endtask
   task automatic t_force();
      wr_reg(8'h0c, 32'h0800_3DBF);
      rd_chk("forced state", 8'h08, 32'h0800_3DF9);
      rd_chk("force readback", 8'h0c, 32'h0000_0000);
      rd_chk("event flags", 8'h18, 32'h0000_000F);
      chk("forced events", 32'(evt), 32'h0000_000F);
      chk("auto power off", 32'(apwr), 32'h0000_0000);
      wr_reg(8'h18, 32'h0000_0005);
      rd_chk("event clear", 8'h18, 32'h0000_000A);
      rd_chk("control idle", 8'h14, 32'h0000_0000);
      // Zero force bits still write their targets
      wr_reg(8'h0c, 32'hF7FF_8040);
      rd_chk("reserved", 8'h08, 32'h0000_0049);
   endtask
   task automatic t_reint();
      addr <= 8'h0c;
      wdata <= 32'h0000_4000;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      n = 0;
      #1;
      while (busy === 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
         #1;
      end
      chk("interrog cycles", 32'(n), 32'h0000_0009);
      @(posedge clk);
      chk("auto power on", 32'(apwr), 32'h0000_0001);
      rd_chk("reinterrogated", 8'h08, 32'h0000_0459);
      rd_chk("control on", 8'h14, 32'h0000_0002);
   endtask
   task automatic t_remove();
      plug <= 1'b0;
      lossy <= 1'b1;
      @(posedge clk);
      lossy <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk("lossy removal", 8'h08, 32'h0000_055F);
      valid <= 1'b0;
      plug <= 1'b1;
      wait_for(1'b1);
      wait_for(1'b0);
      rd_chk("unrecognized", 8'h08, 32'h0000_0080, 32'h0000_0080);
   endtask
   task automatic give_verdict();
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, wr, rd, lossy, pgood, plug, cb, valid, irq, sts} = 10'h200;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_live();
      t_insert();
      t_force();
      t_reint();
      t_remove();
      give_verdict();
   end
   // Whole run is under a hundred cycles; this bound only cuts a hang
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule
